// ==== src/mhs_pkg.sv ====
package mhs_pkg;

	// Register byte offsets.
	localparam logic [7:0] MHS_CTRL_OFF = 8'h00;
	localparam logic [7:0] MHS_CFG_OFF = 8'h04;
	localparam logic [7:0] MHS_HOMING_SPEED_OFF = 8'h08;
	localparam logic [7:0] MHS_CREEP_SPEED_OFF = 8'h0C;
	localparam logic [7:0] MHS_BIAS_SPEED_OFF = 8'h10;
	localparam logic [7:0] MHS_ACCEL_STEP_OFF = 8'h14;
	localparam logic [7:0] MHS_DECEL_STOP_STEP_OFF = 8'h18;
	localparam logic [7:0] MHS_DWELL_OFF = 8'h1C;
	localparam logic [7:0] MHS_ORIGIN_OFF = 8'h20;
	localparam logic [7:0] MHS_STATUS_OFF = 8'h24;
	localparam logic [7:0] MHS_FEED_LOW_OFF = 8'h28;
	localparam logic [7:0] MHS_FEED_HIGH_OFF = 8'h2C;

	// Control register bits, self-clearing on write.
	localparam int MHS_CTRL_START_BIT = 0;
	localparam int MHS_CTRL_HALT_BIT = 1;
	localparam int MHS_CTRL_PROG_STOP_BIT = 2;

	// Configuration register bits.
	localparam int MHS_CFG_DIR_BIT = 0;
	localparam int MHS_CFG_RETRY_BIT = 1;
	localparam int MHS_CFG_LIMITS_BIT = 2;
	localparam int MHS_CFG_READY_USE_BIT = 3;

	// Status register bits.
	localparam int MHS_ST_DONE_BIT = 0;
	localparam int MHS_ST_REQ_BIT = 1;
	localparam int MHS_ST_BUSY_BIT = 2;
	localparam int MHS_ST_STATE_LSB = 4;

	// Reset values.
	localparam logic [31:0] MHS_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] MHS_SPEED_RESET = 32'h0000_0000;
	localparam logic [31:0] MHS_STEP_RESET = 32'h0000_0001;

	// Timing: clock rate and the deviation clear pulse length.
	localparam int MHS_CLK_HZ = 20_000_000;
	localparam int MHS_CLEAR_MS = 10;
	localparam int MHS_CLEAR_CYCLES = MHS_CLK_HZ / 1000 * MHS_CLEAR_MS;
	localparam int MHS_MS_CYCLES = MHS_CLK_HZ / 1000;

	// AXI response codes.
	localparam logic [1:0] MHS_RESP_OKAY = 2'h0;
	localparam logic [1:0] MHS_RESP_SLVERR = 2'h2;

	// Sequencer states.
	typedef enum logic [3:0] {
		MHS_IDLE,
		MHS_ACCEL,
		MHS_DOG_DECEL,
		MHS_CREEP,
		MHS_SEEK_ZERO,
		MHS_STOP_DECEL,
		MHS_RETRY_DECEL,
		MHS_DWELL,
		MHS_CLEAR
	} mhs_state_t;

	// Switch inputs from the machine, all active high.
	typedef struct packed {
		logic near_dog;
		logic zero_signal;
		logic upper_limit_ok;
		logic lower_limit_ok;
		logic drive_ready;
	} mhs_switch_t;

endpackage : mhs_pkg

// ==== src/mhs_sequencer.sv ====
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RQ1 - Start ramps bias to homing speed, holds
// RQ2 - Dog on ramps down to creep speed
// RQ3 - First zero after dog off stops pulses
// RQ4 - Clear held 10 ms, then done set
// RQ5 - Stop causes use deceleration-stop time
// RQ6 - Retry: limit hit, stop, then reverse
// RQ7 - Homing-side limit off triggers retry
// RQ8 - Opposite limit off decelerates to stop
// RQ9 - Dog on at start: creep, no retry
// RQ10 - Early dog release plus zero stops immediately
// RQ11 - Retry only with both limits configured
// RQ12 - Unused terminals free as general purpose
// RQ13 - Dwell time pauses before reverse move
// RQ14 - Host sets direction toward the origin
// RQ15 - Encoder gives one zero per revolution
// RQ16 - External logic synthesizes missing zero
// RQ17 - Dog longer than deceleration distance
// RQ18 - Completion loads origin into feed value
// RQ19 - Forward counts up, reverse counts down
// RQ20 - Bias <= creep <= homing <= limit
// RQ21 - Clock-timed clear; reset returns idle
module mhs_sequencer
	import mhs_pkg::*;
#(
	parameter int CLEAR_CYCLES = MHS_CLEAR_CYCLES,
	parameter int MS_CYCLES = MHS_MS_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mhs_switch_t switches,
	output logic forward_pulse_out,
	output logic reverse_direction_out,
	output logic deviation_clear_out
);

	// Write merge honouring byte strobes.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction : wmerge

	logic [31:0] cfg_ff, homing_speed_ff, creep_speed_ff, bias_speed_ff;
	logic [31:0] accel_step_ff, decel_stop_step_ff, dwell_ms_ff, origin_ff;
	logic start_ff, halt_ff, prog_stop_ff;
	logic aw_got_ff, w_got_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	mhs_state_t state_ff;
	logic [31:0] speed_ff, phase_ff, timer_ff, ms_ff;
	logic [31:0] feed_ff;
	logic dir_ff, done_ff, req_ff, dog_seen_ff, dog_off_ff, retried_ff;
	logic do_write, wr_ok;

	// Write channel: address and data are taken independently, in any order.
	assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign wr_ok = awaddr_ff[7:2] <= MHS_ORIGIN_OFF[7:2] && awaddr_ff[1:0] == 2'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= MHS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_ff <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_got_ff <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? MHS_RESP_OKAY : MHS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Configuration registers; command bits are one-cycle pulses.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_ff <= MHS_CFG_RESET;
			homing_speed_ff <= MHS_SPEED_RESET;
			creep_speed_ff <= MHS_SPEED_RESET;
			bias_speed_ff <= MHS_SPEED_RESET;
			accel_step_ff <= MHS_STEP_RESET;
			decel_stop_step_ff <= MHS_STEP_RESET;
			dwell_ms_ff <= MHS_SPEED_RESET;
			origin_ff <= MHS_SPEED_RESET;
			start_ff <= 1'b0;
			halt_ff <= 1'b0;
			prog_stop_ff <= 1'b0;
		end
		else
		begin
			start_ff <= 1'b0;
			halt_ff <= 1'b0;
			prog_stop_ff <= 1'b0;
			if (do_write)
			begin
				case (awaddr_ff)
					MHS_CTRL_OFF:
					begin
						start_ff <= wstrb_ff[0] && wdata_ff[MHS_CTRL_START_BIT];
						halt_ff <= wstrb_ff[0] && wdata_ff[MHS_CTRL_HALT_BIT];
						prog_stop_ff <= wstrb_ff[0] && wdata_ff[MHS_CTRL_PROG_STOP_BIT];
					end
					MHS_CFG_OFF: cfg_ff <= wmerge(cfg_ff, wdata_ff, wstrb_ff);
					MHS_HOMING_SPEED_OFF:
						homing_speed_ff <= wmerge(homing_speed_ff, wdata_ff, wstrb_ff);
					MHS_CREEP_SPEED_OFF:
						creep_speed_ff <= wmerge(creep_speed_ff, wdata_ff, wstrb_ff);
					MHS_BIAS_SPEED_OFF:
						bias_speed_ff <= wmerge(bias_speed_ff, wdata_ff, wstrb_ff);
					MHS_ACCEL_STEP_OFF:
						accel_step_ff <= wmerge(accel_step_ff, wdata_ff, wstrb_ff);
					MHS_DECEL_STOP_STEP_OFF:
						decel_stop_step_ff <= wmerge(decel_stop_step_ff, wdata_ff, wstrb_ff);
					MHS_DWELL_OFF: dwell_ms_ff <= wmerge(dwell_ms_ff, wdata_ff, wstrb_ff);
					MHS_ORIGIN_OFF: origin_ff <= wmerge(origin_ff, wdata_ff, wstrb_ff);
					default: ;
				endcase
			end
		end
	end

	// Read channel: one cycle from address to data.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= MHS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= MHS_RESP_OKAY;
			case (s_axi_araddr)
				MHS_CFG_OFF: s_axi_rdata <= cfg_ff;
				MHS_HOMING_SPEED_OFF: s_axi_rdata <= homing_speed_ff;
				MHS_CREEP_SPEED_OFF: s_axi_rdata <= creep_speed_ff;
				MHS_BIAS_SPEED_OFF: s_axi_rdata <= bias_speed_ff;
				MHS_ACCEL_STEP_OFF: s_axi_rdata <= accel_step_ff;
				MHS_DECEL_STOP_STEP_OFF: s_axi_rdata <= decel_stop_step_ff;
				MHS_DWELL_OFF: s_axi_rdata <= dwell_ms_ff;
				MHS_ORIGIN_OFF: s_axi_rdata <= origin_ff;
				MHS_STATUS_OFF: s_axi_rdata <= {24'h00_0000, state_ff, 1'b0,
					state_ff != MHS_IDLE, req_ff, done_ff};
				MHS_FEED_LOW_OFF: s_axi_rdata <= {16'h0000, feed_ff[15:0]};
				MHS_FEED_HIGH_OFF: s_axi_rdata <= {16'h0000, feed_ff[31:16]};
				MHS_CTRL_OFF: s_axi_rdata <= 32'h0000_0000;
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= MHS_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Homing sequencer. Speed is in phase units per clock; a pulse is emitted
	// each time the phase accumulator wraps, so speed sets pulse frequency.
	// A low limit input is a hit; after a retry only the far limit may stop the axis.
	logic limits_on, home_rev, fwd_limit_hit, rev_limit_hit, stop_cause;
	logic [32:0] phase_sum;
	assign limits_on = cfg_ff[MHS_CFG_LIMITS_BIT]; // RQ11 RQ12
	assign home_rev = dir_ff ^ retried_ff;
	assign fwd_limit_hit = limits_on && !retried_ff && (home_rev ? !switches.lower_limit_ok
		: !switches.upper_limit_ok); // RQ7
	assign rev_limit_hit = limits_on && (home_rev ? !switches.upper_limit_ok
		: !switches.lower_limit_ok); // RQ8
	assign stop_cause = halt_ff || prog_stop_ff
		|| (cfg_ff[MHS_CFG_READY_USE_BIT] && !switches.drive_ready); // RQ5
	assign phase_sum = {1'b0, phase_ff} + {1'b0, speed_ff};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= MHS_IDLE; // RQ21
			speed_ff <= 32'h0000_0000;
			phase_ff <= 32'h0000_0000;
			timer_ff <= 32'h0000_0000;
			ms_ff <= 32'h0000_0000;
			feed_ff <= 32'h0000_0000;
			dir_ff <= 1'b0;
			done_ff <= 1'b0;
			req_ff <= 1'b1;
			dog_seen_ff <= 1'b0;
			dog_off_ff <= 1'b0;
			retried_ff <= 1'b0;
			forward_pulse_out <= 1'b0;
			reverse_direction_out <= 1'b0;
			deviation_clear_out <= 1'b0;
		end
		else
		begin
			forward_pulse_out <= 1'b0;
			// Pulses only while moving; each pulse moves the feed value one step.
			if (state_ff inside {MHS_ACCEL, MHS_DOG_DECEL, MHS_CREEP, MHS_SEEK_ZERO,
				MHS_STOP_DECEL, MHS_RETRY_DECEL})
			begin
				phase_ff <= phase_sum[31:0];
				if (phase_sum[32])
				begin
					forward_pulse_out <= 1'b1;
					feed_ff <= dir_ff ? feed_ff - 32'h0000_0001 : feed_ff + 32'h0000_0001; // RQ19
				end
			end
			reverse_direction_out <= dir_ff;
			case (state_ff)
				MHS_IDLE:
					if (start_ff)
					begin
						req_ff <= 1'b1;
						done_ff <= 1'b0;
						dir_ff <= cfg_ff[MHS_CFG_DIR_BIT];
						retried_ff <= 1'b0;
						dog_off_ff <= 1'b0;
						dog_seen_ff <= switches.near_dog;
						// Starting on the dog goes straight to creep without retry.
						state_ff <= switches.near_dog ? MHS_CREEP : MHS_ACCEL; // RQ9
						speed_ff <= switches.near_dog ? creep_speed_ff : bias_speed_ff; // RQ1 RQ9
					end
				MHS_ACCEL, MHS_DOG_DECEL, MHS_CREEP, MHS_SEEK_ZERO:
				begin
					if (switches.near_dog)
						dog_seen_ff <= 1'b1;
					if (dog_seen_ff && !switches.near_dog)
						dog_off_ff <= 1'b1;
					if (stop_cause || rev_limit_hit) // RQ8
						state_ff <= MHS_STOP_DECEL; // RQ5
					else if (fwd_limit_hit)
						state_ff <= (cfg_ff[MHS_CFG_RETRY_BIT] && !dog_seen_ff && !retried_ff)
							? MHS_RETRY_DECEL : MHS_STOP_DECEL; // RQ6
					else if (dog_off_ff && switches.zero_signal)
					begin
						// Zero after release stops at once, even above creep.
						speed_ff <= 32'h0000_0000; // RQ3 RQ10
						timer_ff <= 32'h0000_0000;
						deviation_clear_out <= 1'b1;
						state_ff <= MHS_CLEAR;
					end
					else if (state_ff == MHS_ACCEL)
					begin
						if (switches.near_dog)
							state_ff <= MHS_DOG_DECEL; // RQ2
						else
							speed_ff <= (speed_ff + accel_step_ff >= homing_speed_ff)
								? homing_speed_ff : speed_ff + accel_step_ff; // RQ1
					end
					else if (state_ff == MHS_DOG_DECEL)
						if (speed_ff <= creep_speed_ff + accel_step_ff)
						begin
							speed_ff <= creep_speed_ff; // RQ2
							state_ff <= MHS_CREEP;
						end
						else
							speed_ff <= speed_ff - accel_step_ff; // RQ2
				end
				MHS_STOP_DECEL, MHS_RETRY_DECEL:
				begin
					// Stop causes use the separate deceleration-stop step.
					if (speed_ff <= bias_speed_ff + decel_stop_step_ff)
					begin
						speed_ff <= 32'h0000_0000;
						timer_ff <= 32'h0000_0000;
						ms_ff <= 32'h0000_0000;
						state_ff <= state_ff == MHS_RETRY_DECEL ? MHS_DWELL : MHS_IDLE;
					end
					else
						speed_ff <= speed_ff - decel_stop_step_ff; // RQ5
				end
				MHS_DWELL:
				begin
					// Millisecond prescaler keeps the dwell counter short.
					if (ms_ff == MS_CYCLES - 1)
					begin
						ms_ff <= 32'h0000_0000;
						timer_ff <= timer_ff + 32'h0000_0001;
					end
					else
						ms_ff <= ms_ff + 32'h0000_0001;
					if (timer_ff >= dwell_ms_ff)
					begin
						dir_ff <= !dir_ff; // RQ6 RQ13
						retried_ff <= 1'b1;
						speed_ff <= bias_speed_ff;
						state_ff <= MHS_ACCEL;
					end
				end
				MHS_CLEAR:
				begin
					if (timer_ff == CLEAR_CYCLES - 1) // RQ4 RQ21
					begin
						deviation_clear_out <= 1'b0;
						done_ff <= 1'b1; // RQ4
						req_ff <= 1'b0; // RQ4
						feed_ff <= origin_ff; // RQ18
						state_ff <= MHS_IDLE;
					end
					else
						timer_ff <= timer_ff + 32'h0000_0001;
				end
				default: state_ff <= MHS_IDLE;
			endcase
		end
	end

endmodule : mhs_sequencer

// ==== test/mhs_drive_model.sv ====
`timescale 1ns/1ps
// Behavioural axis: counts steps and makes the zero mark, dog and limit switches.
module mhs_drive_model
	import mhs_pkg::*;
#(
	parameter int REV = 16,
	parameter int DOG_LO = 100,
	parameter int DOG_HI = 170,
	parameter int UP_END = 400,
	parameter int LOW_END = -100
)
(
	input wire logic aclk,
	input wire logic step,
	input wire logic dir_rev,
	input wire logic load,
	input wire logic [31:0] load_pos,
	input wire logic ready,
	input wire logic low_cut,
	output mhs_switch_t switches
);
	int pos = 0;
	int nxt;
	logic zero = 1'b0;
	// Reverse steps count down, forward steps count up.
	always @(posedge aclk)
	begin
		nxt = dir_rev ? pos - 1 : pos + 1;
		zero <= step && !load && (nxt % REV == 0);
		if (load)
			pos <= int'(load_pos);
		else if (step)
			pos <= nxt;
	end
	// The dog is longer than the slowdown distance; low_cut fakes a hit on the lower limit.
	assign switches = {pos >= DOG_LO && pos < DOG_HI, zero, pos < UP_END,
		pos > LOW_END && !low_cut, ready};
endmodule : mhs_drive_model

// ==== test/mhs_sequencer_bench.sv ====
`timescale 1ns/1ps
module mhs_sequencer_bench
	import mhs_pkg::*;
;
	localparam int CLR = 20;
	localparam logic [31:0] TAB [7] = '{32'h2000_0000, 32'h0800_0000, 32'h0100_0000,
		32'h0010_0000, 32'h0040_0000, 32'h1, 32'h0001_2345};
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, load_pos = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic forward_pulse_out, reverse_direction_out, deviation_clear_out;
	logic load = 1'b0, ready = 1'b1, low_cut = 1'b0, saw_rev, saw_clr;
	mhs_switch_t switches;
	int num_errors = 0, n_tests = 0, clr_cnt = 0, clr_len = 0, cyc = 0;
	mhs_sequencer #(.CLEAR_CYCLES(CLR), .MS_CYCLES(4)) i_dut (.*);
	mhs_drive_model i_drv (.aclk, .step(forward_pulse_out), .dir_rev(reverse_direction_out),
		.load, .load_pos, .ready, .low_cut, .switches);
	initial
		forever #25 aclk = ~aclk;
	// Watches the clear pulse and direction; the ceiling cuts a hung run short.
	always @(posedge aclk)
	begin
		cyc++;
		if (deviation_clear_out === 1'b1)
		begin
			clr_cnt++;
			saw_clr = 1'b1;
		end
		else if (clr_cnt != 0)
		begin
			clr_len = clr_cnt;
			clr_cnt = 0;
		end
		if (reverse_direction_out === 1'b1)
			saw_rev = 1'b1;
		if (cyc == 60000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// Address and data are offered together; each drops once its own ready is seen.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && s_axi_awready)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axr
	// Polls busy; the cycle ceiling bounds the wait.
	task automatic wait_idle(output logic [31:0] d);
		logic [1:0] r;
		d = 32'h4;
		while (d[MHS_ST_BUSY_BIT] !== 1'b0)
			axr(MHS_STATUS_OFF, d, r);
	endtask : wait_idle
	task automatic go(input logic [31:0] cfg, input logic [31:0] p);
		logic [1:0] r;
		load_pos <= p;
		load <= 1'b1;
		@(posedge aclk);
		load <= 1'b0;
		axw(MHS_CFG_OFF, cfg, r);
		saw_rev = 1'b0;
		saw_clr = 1'b0;
		clr_len = 0;
		axw(MHS_CTRL_OFF, 32'h1, r);
	endtask : go
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axr(MHS_STATUS_OFF, d, r);
		chk(d, 32'h2);
		axr(8'h30, d, r);
		chk({d[29:0], r}, {30'h0, MHS_RESP_SLVERR});
		axw(MHS_STATUS_OFF, 32'h0, r);
		chk(32'(r), 32'(MHS_RESP_SLVERR));
		for (int i = 0; i < 7; i++)
		begin
			axw(MHS_HOMING_SPEED_OFF + 8'(4 * i), TAB[i], r);
			chk(32'(r), 32'(MHS_RESP_OKAY));
		end
		axr(MHS_ACCEL_STEP_OFF, d, r);
		chk(d, TAB[3]);
		$display("t_regs done");
	endtask : t_regs
	// Halt, program stop, drive ready loss and the far limit each stop without done.
	task automatic t_stops;
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 4; k++)
		begin
			go(32'hC, 32'h0);
			repeat (300) @(posedge aclk);
			if (k < 2)
				axw(MHS_CTRL_OFF, 32'h2 << k, r);
			else if (k == 2)
				ready <= 1'b0;
			else
				low_cut <= 1'b1;
			wait_idle(d);
			ready <= 1'b1;
			low_cut <= 1'b0;
			chk(32'(d[1:0]), 32'h2);
			chk(32'(saw_clr), 32'h0);
		end
		$display("t_stops done");
	endtask : t_stops
	// Homes from p; checks clear length, direction seen, done and the loaded origin.
	task automatic t_home(input logic [31:0] cfg, input logic [31:0] p, input logic rv);
		logic [31:0] d;
		logic [1:0] r;
		go(cfg, p);
		wait_idle(d);
		chk(32'(d[1:0]), 32'h1);
		chk(32'(clr_len), 32'(CLR));
		chk(32'(saw_rev), 32'(rv));
		axr(MHS_FEED_LOW_OFF, d, r);
		chk(d, {16'h0, TAB[6][15:0]});
		axr(MHS_FEED_HIGH_OFF, d, r);
		chk(d, {16'h0, TAB[6][31:16]});
		$display("t_home done");
	endtask : t_home
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_stops();
		t_home(32'h0, 32'h0, 1'b0);
		t_home(32'h6, 32'h78, 1'b0);
		t_home(32'h6, 32'hC8, 1'b1);
		t_home(32'h7, 32'hC8, 1'b1);
		report_and_stop();
	end
endmodule : mhs_sequencer_bench
bind mhs_sequencer mhs_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (.*);

// ==== test/mhs_sva.sv ====
`timescale 1ns/1ps
// Port checks for the homing sequencer; it sees only the top ports.
module mhs_sva
	import mhs_pkg::*;
#(
	parameter int CLEAR_CYCLES = MHS_CLEAR_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mhs_switch_t switches,
	input wire logic forward_pulse_out,
	input wire logic reverse_direction_out,
	input wire logic deviation_clear_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int clr_ff;
	// Counts clear cycles, so a pulse cut short or stretched is caught at its end.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !deviation_clear_out)
			clr_ff <= 0;
		else
			clr_ff <= clr_ff + 1;
	end
	property p_clr_len; $fell(deviation_clear_out) |-> clr_ff == CLEAR_CYCLES; endproperty
	a_clr_len: assert property (p_clr_len) else $error("clear length");
	property p_clr_cap; deviation_clear_out |-> clr_ff < CLEAR_CYCLES; endproperty
	a_clr_cap: assert property (p_clr_cap) else $error("clear too long");
	property p_clr_why; $rose(deviation_clear_out) |-> $past(switches.zero_signal); endproperty
	a_clr_why: assert property (p_clr_why) else $error("clear without zero");
	property p_clr_quiet; deviation_clear_out |-> !forward_pulse_out; endproperty
	a_clr_quiet: assert property (p_clr_quiet) else $error("pulse during clear");
	property p_rst;
		disable iff (1'b0) !aresetn |=> !forward_pulse_out && !deviation_clear_out;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live in reset");
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("no write response");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("no read data");
	property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rd_once: assert property (p_rd_once) else $error("read data repeated");
	c_done: cover property ($fell(deviation_clear_out));
	c_rev: cover property ($rose(reverse_direction_out));
	c_dog: cover property ($fell(switches.near_dog));
endmodule : mhs_sva
